// *** design/ibs_decode.v ***
// Purpose: classify an opcode byte into a bus-cycle class
// Assumes: page flag set when a $18 prefix was already fetched
// Notes:   unsupported opcodes fall back to a two-cycle read
`include "ibs_regs.vh"

module ibs_decode (
    input  wire [7:0] opcode,     // fetched opcode byte
    input  wire       page2,      // second byte of a prefixed opcode
    output reg  [3:0] op_class    // decoded class
);

    // pure lookup, no state
    always @*
    begin
        op_class = `IBS_CL_OTHER;
        if (page2)
        begin
            case (opcode)
                `IBS_OP2_LOAD_Y_IMM:  op_class = `IBS_CL_IMMLDY;
                8'h8C:                op_class = `IBS_CL_IMMCPY; // cmp y imm
                `IBS_OP2_LOAD_Y_DIR:  op_class = `IBS_CL_DIRLDY;
                `IBS_OP2_STORE_Y_DIR: op_class = `IBS_CL_DIRSTY;
                8'h9C:                op_class = `IBS_CL_DIRCPY; // cmp y dir
                default:          op_class = `IBS_CL_OTHER;
            endcase
        end
        else
        begin
            case (opcode)
                `IBS_PAGE_PREFIX: op_class = `IBS_CL_PFX;
                8'hCC, 8'hCE, 8'h8E:
                    op_class = `IBS_CL_IMM16LD;  // ld d/x/sp imm
                8'hC3, 8'h83, 8'h8C:
                    op_class = `IBS_CL_IMM16AR;  // add/sub d, cmp x
                8'hDC, 8'hDE, 8'h9E:
                    op_class = `IBS_CL_DIR16LD;
                8'hDD, 8'hDF, 8'h9F:
                    op_class = `IBS_CL_DIR16ST;
                8'h97, 8'hD7:
                    op_class = `IBS_CL_DIR8ST;   // store acc a/b
                default:
                begin
                    // 8-bit accumulator ops: column 8x/Cx imm, 9x/Dx dir
                    if (opcode[7] && opcode[5:4] == 2'b00)
                        op_class = `IBS_CL_IMM8;
                    else if (opcode[7] && opcode[5:4] == 2'b01)
                        op_class = `IBS_CL_DIR8RD;
                    else
                        op_class = `IBS_CL_OTHER;
                end
            endcase
        end
    end

endmodule

// *** design/ibs_regs.vh ***
// Purpose: constants for the immediate/direct bus-cycle sequencer
// Assumes: 8-bit data bus, 16-bit address bus
// Notes:   opcode classes are decoded by ibs_decode
`ifndef IBS_REGS_VH
`define IBS_REGS_VH

// page-select prefix and second opcode bytes
`define IBS_PAGE_PREFIX     8'h18
`define IBS_OP2_LOAD_Y_IMM  8'hEC
`define IBS_OP2_LOAD_Y_DIR  8'hDE
`define IBS_OP2_STORE_Y_DIR 8'hDF
// dummy-cycle address and zero-page high byte
`define IBS_DUMMY_ADDR      16'hFFFF
`define IBS_ZPAGE_HI        8'h00
// reset values
`define IBS_RESET_PC        16'h0000
// instruction class codes, 4 bits
`define IBS_CL_IMM8         4'h0
`define IBS_CL_IMM16LD      4'h1
`define IBS_CL_IMM16AR      4'h2
`define IBS_CL_DIR8RD       4'h3
`define IBS_CL_DIR8ST       4'h4
`define IBS_CL_DIR16LD      4'h5
`define IBS_CL_DIR16ST      4'h6
`define IBS_CL_PFX          4'h7
`define IBS_CL_IMMLDY       4'h8
`define IBS_CL_IMMCPY       4'h9
`define IBS_CL_DIRLDY       4'hA
`define IBS_CL_DIRSTY       4'hB
`define IBS_CL_DIRCPY       4'hC
`define IBS_CL_OTHER        4'hF

`endif

// *** design/ibs_sequencer.v ***
// Purpose: bus-cycle sequencer for immediate and direct addressing
// Assumes: memory answers reads in the same bus cycle (rd_data valid)
// Notes:   one bus cycle per sys_clk; no idle cycles between opcodes
//
// Function
// - immediate 8-bit ops: opcode then operand
// - immediate 16-bit loads: opcode, high, low
// - immediate 16-bit arith: three reads, dummy $FFFF
// - immediate y load: prefix, $EC, high, low
// - immediate y compare: five cycles, dummy last
// - direct: fetched byte is low, high $00
// - direct 8-bit read ops take three reads
// - direct 8-bit store writes accumulator third cycle
// - direct 16-bit loads: high then low byte
// - direct 16-bit stores write high then low
// - direct y load: prefix, $DE, addr, data
// - direct y store: prefix, $DF, addr, write high
// - fifth y store cycle writes low byte
`include "ibs_regs.vh"

module ibs_sequencer (
    input  wire        sys_clk,      // bus clock
    input  wire        srst,         // sync reset, high
    input  wire [7:0]  rd_data,      // data bus read value
    input  wire [7:0]  acc_byte,     // accumulator for 8-bit store
    input  wire [15:0] reg_word,     // register for 16-bit store
    output reg  [15:0] bus_addr,     // address bus
    output reg         bus_rw,       // 1 read, 0 write
    output reg  [7:0]  wr_data,      // data bus on writes
    output reg         opc_fetch,    // cycle is an opcode fetch
    output reg  [3:0]  cyc_num       // cycle number within instruction
);

    // one-hot states
    localparam [6:0] S_OPC   = 7'b0000001; // opcode fetch
    localparam [6:0] S_OP2   = 7'b0000010; // second opcode byte
    localparam [6:0] S_IMM   = 7'b0000100; // immediate operand bytes
    localparam [6:0] S_ZADR  = 7'b0001000; // direct low address byte
    localparam [6:0] S_DAT   = 7'b0010000; // operand data cycles
    localparam [6:0] S_DUMMY = 7'b0100000; // ignored read at $FFFF
    localparam [6:0] S_LAST  = 7'b1000000; // unsupported-opcode filler read, returns to fetch

    reg  [6:0]  st_q, st_d;          // sequencer state
    reg  [15:0] pc_q, pc_d;          // next instruction byte address
    reg  [7:0]  zlo_q, zlo_d;        // captured direct low address
    reg  [3:0]  cls_q, cls_d;        // class of current instruction
    reg  [1:0]  cnt_q, cnt_d;        // bytes left in current phase
    reg         dat_q, dat_d;        // second byte of data phase
    reg  [3:0]  cyc_d;               // next cycle number
    reg  [15:0] addr_d;              // next address
    reg         rw_d;                // next rw level
    reg  [7:0]  wd_d;                // next write data
    reg         pg2_q, pg2_d;        // prefix seen

    wire [3:0]  dec_class;           // class of byte on data bus
    wire [15:0] zp_addr = {`IBS_ZPAGE_HI, zlo_q};

    ibs_decode u_dec (
        .opcode   (rd_data),
        .page2    (pg2_q),
        .op_class (dec_class)
    );

    // class wants 16-bit operand data
    function wide16;
        input [3:0] c;
        begin
            wide16 = (c == `IBS_CL_IMM16LD) || (c == `IBS_CL_IMM16AR) ||
                     (c == `IBS_CL_IMMLDY)  || (c == `IBS_CL_IMMCPY)  ||
                     (c == `IBS_CL_DIR16LD) || (c == `IBS_CL_DIR16ST) ||
                     (c == `IBS_CL_DIRLDY)  || (c == `IBS_CL_DIRSTY)  ||
                     (c == `IBS_CL_DIRCPY);
        end
    endfunction

    // immediate class ends with a dummy read
    function dummy_end;
        input [3:0] c;
        begin
            dummy_end = (c == `IBS_CL_IMM16AR) || (c == `IBS_CL_IMMCPY);
        end
    endfunction

    // class is a store
    function is_store;
        input [3:0] c;
        begin
            is_store = (c == `IBS_CL_DIR8ST) || (c == `IBS_CL_DIR16ST) ||
                       (c == `IBS_CL_DIRSTY);
        end
    endfunction

    // class uses direct addressing
    function is_direct;
        input [3:0] c;
        begin
            is_direct = (c == `IBS_CL_DIR8RD)  || (c == `IBS_CL_DIR8ST) ||
                        (c == `IBS_CL_DIR16LD) || (c == `IBS_CL_DIR16ST) ||
                        (c == `IBS_CL_DIRLDY)  || (c == `IBS_CL_DIRSTY) ||
                        (c == `IBS_CL_DIRCPY);
        end
    endfunction

    // next-cycle decision; each state emits the next bus cycle
    always @*
    begin
        st_d   = st_q;
        pc_d   = pc_q;
        zlo_d  = zlo_q;
        cls_d  = cls_q;
        cnt_d  = cnt_q;
        dat_d  = dat_q;
        pg2_d  = pg2_q;
        cyc_d  = cyc_num + 4'h1;
        addr_d = pc_q;
        rw_d   = 1'b1;
        wd_d   = 8'h00;
        case (st_q)
            S_OPC, S_OP2:
            begin
                // byte on rd_data is an opcode; next fetch at pc
                cls_d  = dec_class;
                pc_d   = pc_q + 16'h0001;
                if (dec_class == `IBS_CL_PFX)
                begin
                    // prefix: read second opcode byte
                    pg2_d = 1'b1;
                    st_d  = S_OP2;
                end
                else if (is_direct(dec_class))
                begin
                    pg2_d = 1'b0;
                    st_d  = S_ZADR;
                end
                else if (dec_class == `IBS_CL_OTHER)
                begin
                    // unsupported: one filler read, then fetch
                    pg2_d = 1'b0;
                    st_d  = S_LAST;
                end
                else
                begin
                    // immediate: 1 or 2 operand bytes
                    pg2_d = 1'b0;
                    cnt_d = wide16(dec_class) ? 2'd2 : 2'd1;
                    st_d  = S_IMM;
                end
            end
            S_IMM:
            begin
                pc_d  = pc_q + 16'h0001;
                cnt_d = cnt_q - 2'd1;
                if (cnt_q == 2'd1)
                begin
                    if (dummy_end(cls_q))
                    begin
                        // dummy read uses no program byte, pc holds
                        pc_d   = pc_q;
                        addr_d = `IBS_DUMMY_ADDR;
                        st_d   = S_DUMMY;
                    end
                    else
                    begin
                        cyc_d = 4'h1;
                        st_d  = S_OPC;
                    end
                end
            end
            S_ZADR:
            begin
                // low address byte on data bus, high forced to $00
                // pc already points past the address byte; bus leaves it
                zlo_d  = rd_data;
                addr_d = {`IBS_ZPAGE_HI, rd_data};
                dat_d  = 1'b0;
                st_d   = S_DAT;
                if (is_store(cls_q))
                begin
                    rw_d = 1'b0;
                    wd_d = (cls_q == `IBS_CL_DIR8ST) ? acc_byte
                                                     : reg_word[15:8];
                end
            end
            S_DAT:
            begin
                if (wide16(cls_q) && !dat_q)
                begin
                    // second data byte at operand address + 1
                    dat_d  = 1'b1;
                    addr_d = zp_addr + 16'h0001;
                    if (is_store(cls_q))
                    begin
                        rw_d = 1'b0;
                        wd_d = reg_word[7:0];
                    end
                end
                else if (dummy_end(cls_q) || cls_q == `IBS_CL_DIRCPY)
                begin
                    addr_d = `IBS_DUMMY_ADDR;
                    st_d   = S_DUMMY;
                end
                else
                begin
                    cyc_d = 4'h1;
                    st_d  = S_OPC;
                end
            end
            S_DUMMY, S_LAST:
            begin
                // data ignored; next opcode sits at pc
                cyc_d = 4'h1;
                st_d  = S_OPC;
            end
            default:
            begin
                cyc_d = 4'h1;
                st_d  = S_OPC;
            end
        endcase
    end

    // state and bus outputs, all registered
    always @(posedge sys_clk)
    begin
        if (srst)
        begin
            st_q      <= S_OPC;
            pc_q      <= `IBS_RESET_PC + 16'h0001;
            zlo_q     <= 8'h00;
            cls_q     <= `IBS_CL_OTHER;
            cnt_q     <= 2'd0;
            dat_q     <= 1'b0;
            pg2_q     <= 1'b0;
            bus_addr  <= `IBS_RESET_PC;
            bus_rw    <= 1'b1;
            wr_data   <= 8'h00;
            opc_fetch <= 1'b1;
            cyc_num   <= 4'h1;
        end
        else
        begin
            st_q      <= st_d;
            pc_q      <= (st_d == S_OPC && st_q != S_OPC && st_q != S_OP2)
                         ? addr_d + 16'h0001 : pc_d;
            zlo_q     <= zlo_d;
            cls_q     <= cls_d;
            cnt_q     <= cnt_d;
            dat_q     <= dat_d;
            pg2_q     <= pg2_d;
            bus_addr  <= addr_d;
            bus_rw    <= rw_d;
            wr_data   <= wd_d;
            opc_fetch <= (st_d == S_OPC) || (st_d == S_OP2);
            cyc_num   <= cyc_d;
        end
    end

endmodule

// *** dv/ibs_mem_model.sv ***
// Purpose: memory and peripherals on the far side of the sequencer
// Assumes: reads answer in the same bus cycle, writes land on the edge
// Notes:   a write cycle leaves rd_data showing the inverse of its last value
module ibs_mem_model (
    input  wire logic        sys_clk,  // bus clock
    input  wire logic [15:0] bus_addr, // address bus
    input  wire logic        bus_rw,   // 1 read, 0 write
    input  wire logic [7:0]  wr_data,  // data bus on writes
    output logic      [7:0]  rd_data   // data bus on reads
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem [0:65535];         // whole 64k space, filled by the bench
    logic [7:0] last_q = 8'h00;        // last byte driven on reads

    // combinational read so the same cycle sees its data
    always_comb
    begin
        if (bus_rw)
            rd_data = mem[bus_addr];
        else
            rd_data = ~last_q;         // bus not driven by memory on writes
    end

    // writes commit on the edge that closes the cycle
    always @(posedge sys_clk)
    begin
        if (!bus_rw)
            mem[bus_addr] <= wr_data;
        else
            last_q <= rd_data;
    end
endmodule

// *** dv/ibs_seq_assertions.sv ***
// Purpose: cycle-order checks on the sequencer ports
// Assumes: opcodes as decoded by the design, no $18 inside operands
// Notes:   one clock domain, so default clocking and disable are used
module ibs_seq_checker (
    input logic        sys_clk,
    input logic        srst,
    input logic [7:0]  rd_data,
    input logic [7:0]  acc_byte,
    input logic [15:0] reg_word,
    input logic [15:0] bus_addr,
    input logic        bus_rw,
    input logic [7:0]  wr_data,
    input logic        opc_fetch,
    input logic [3:0]  cyc_num
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    // first cycle of an instruction carrying a given opcode
    sequence s_op(logic [7:0] op);
        opc_fetch && cyc_num == 4'h1 && rd_data == op;
    endsequence
    // page prefix followed by a given second byte
    sequence s_pg(logic [7:0] op2);
        s_op(8'h18) ##1 rd_data == op2;
    endsequence
    // a fresh opcode fetch
    sequence s_next;
        opc_fetch && cyc_num == 4'h1;
    endsequence

    // address checks sit in the last cycle they describe, so $past
    // reaches back no further than the opcode cycle and never across a reset
    AST_RESET_START: assert property (
        $fell(srst) |-> s_next and bus_addr == 16'h0000 and bus_rw)
        else $error("no opcode fetch at 0000 after reset");
    AST_IMM8: assert property (
        s_op(8'h86) |=> bus_addr == $past(bus_addr) + 16'h0001
        ##1 (s_next and bus_addr == $past(bus_addr, 2) + 16'h0002))
        else $error("immediate byte op length wrong");
    AST_IMM16_LD: assert property (
        s_op(8'hCC) |=>
        ##2 (s_next and bus_addr == $past(bus_addr, 3) + 16'h0003))
        else $error("immediate word load length wrong");
    AST_IMM16_DUMMY: assert property (
        s_op(8'hC3) |=> ##2 (bus_addr == 16'hFFFF && bus_rw) ##1 s_next)
        else $error("dummy read missing after word add");
    AST_IMM_LOAD_Y: assert property (
        s_pg(8'hEC) |=>
        ##2 (s_next and bus_addr == $past(bus_addr, 4) + 16'h0004))
        else $error("immediate y load length wrong");
    AST_COMPARE_Y_DUMMY: assert property (
        s_pg(8'h8C) |=> ##2 (bus_addr == 16'hFFFF && bus_rw) ##1 s_next)
        else $error("dummy read missing after y compare");
    AST_DIR_ZPAGE: assert property (
        s_op(8'h96) |=> ##1 (bus_addr == {8'h00, $past(rd_data)} && bus_rw)
        ##1 s_next)
        else $error("direct read not in zero page");
    AST_DIR8_STORE: assert property (
        s_op(8'h97) |=> ##1 (!bus_rw && wr_data == $past(acc_byte)))
        else $error("byte store write cycle wrong");
    AST_DIR16_LD: assert property (
        s_op(8'hDC) |=> ##2 (bus_addr == $past(bus_addr) + 16'h0001 && bus_rw)
        ##1 s_next)
        else $error("direct word load order wrong");
    AST_DIR16_STORE: assert property (
        s_op(8'hDD) |=> ##1 (!bus_rw && wr_data == $past(reg_word[15:8]))
        ##1 (!bus_rw && wr_data == $past(reg_word[7:0])))
        else $error("word store writes wrong");
    AST_STORE_Y_FIFTH: assert property (
        s_pg(8'hDF) |=> ##1 (!bus_rw && bus_addr == {8'h00, $past(rd_data)})
        ##1 (!bus_rw && bus_addr == $past(bus_addr) + 16'h0001))
        else $error("y store writes wrong");
    AST_ONE_CYCLE: assert property (
        !(opc_fetch && cyc_num == 4'h1) |-> cyc_num == $past(cyc_num) + 4'h1)
        else $error("cycle count skipped or stalled");
endmodule

bind ibs_sequencer ibs_seq_checker chk_u (
    .sys_clk(sys_clk), .srst(srst), .rd_data(rd_data), .acc_byte(acc_byte),
    .reg_word(reg_word), .bus_addr(bus_addr), .bus_rw(bus_rw),
    .wr_data(wr_data), .opc_fetch(opc_fetch), .cyc_num(cyc_num)
);

// *** dv/test_immediate_direct_bus_sequencer.sv ***
// Purpose: run short programs and compare every bus cycle
// Assumes: execution starts at 0000 after each reset
// Notes:   filler byte 01 keeps the run going past each program
`define IBS_CHK(what, exp, got) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) \
        begin \
            fails++; \
            $display("Error %s expected %h seen %h", what, exp, got); \
        end \
    end
module test_immediate_direct_bus_sequencer;
    timeunit 1ns;
    timeprecision 100ps;
    typedef logic [7:0]  ibs_prog_t[$];   // program bytes from 0000
    typedef logic [24:0] ibs_trace_t[$];  // {addr, rw, write data}
    localparam logic [7:0]  ACC = 8'h5A;   // accumulator for byte stores
    localparam logic [15:0] REG = 16'hC3A7; // register for word stores
    logic        sys_clk  = 1'b0;
    logic        srst     = 1'b1;
    logic [7:0]  acc_byte = ACC;
    logic [15:0] reg_word = REG;
    logic [7:0]  rd_data;
    logic [15:0] bus_addr;
    logic        bus_rw;
    logic [7:0]  wr_data;
    logic        opc_fetch;
    logic [3:0]  cyc_num;
    int          fails       = 0;
    int          checks_done = 0;

    always #2 sys_clk = ~sys_clk;

    ibs_sequencer dut_u (.sys_clk(sys_clk), .srst(srst), .rd_data(rd_data),
        .acc_byte(acc_byte), .reg_word(reg_word), .bus_addr(bus_addr),
        .bus_rw(bus_rw), .wr_data(wr_data), .opc_fetch(opc_fetch),
        .cyc_num(cyc_num));
    ibs_mem_model mem_u (.sys_clk(sys_clk), .bus_addr(bus_addr),
        .bus_rw(bus_rw), .wr_data(wr_data), .rd_data(rd_data));

    // expected read and write cycles
    function automatic logic [24:0] rc(input logic [15:0] a);
        return {a, 1'b1, 8'h00};
    endfunction
    function automatic logic [24:0] wc(input logic [15:0] a,
                                       input logic [7:0] d);
        return {a, 1'b0, d};
    endfunction

    // reset, load program, then follow the trace cycle by cycle
    task automatic run(input ibs_prog_t prog, input ibs_trace_t exp);
        logic [24:0] e;
        @(posedge sys_clk);
        srst <= 1'b1;
        // reload off the edge, after any write the model commits there
        #1;
        for (int i = 0; i < 65536; i++)
            mem_u.mem[i] = 8'h01;
        foreach (prog[i])
            mem_u.mem[i] = prog[i];
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        foreach (exp[i])
        begin
            e = exp[i];
            #1;
            `IBS_CHK("bus_addr", e[24:9], bus_addr)
            `IBS_CHK("bus_rw", e[8], bus_rw)
            if (!e[8])
                `IBS_CHK("wr_data", e[7:0], wr_data)
            // each trace starts and ends on an opcode fetch
            if (i == 0 || i == exp.size() - 1)
            begin
                `IBS_CHK("opc_fetch", 1'b1, opc_fetch)
                `IBS_CHK("cyc_num", 4'h1, cyc_num)
            end
            @(posedge sys_clk);
        end
    endtask

    // byte ops: immediate load, direct load, direct store back to back
    task automatic test_byte_ops;
        run('{8'h86, 8'h11, 8'h96, 8'h40, 8'h97, 8'h41},
            '{rc(16'h0000), rc(16'h0001), rc(16'h0002), rc(16'h0003),
              rc(16'h0040), rc(16'h0004), rc(16'h0005),
              wc(16'h0041, ACC), rc(16'h0006)});
    endtask

    // immediate word ops, including both dummy reads at FFFF
    task automatic test_imm_words;
        run('{8'hCC, 8'h12, 8'h34, 8'hC3, 8'h00, 8'h01, 8'h18, 8'hEC,
              8'h00, 8'h02, 8'h18, 8'h8C, 8'h00, 8'h03},
            '{rc(16'h0000), rc(16'h0001), rc(16'h0002),
              rc(16'h0003), rc(16'h0004), rc(16'h0005),
              rc(16'hFFFF),
              rc(16'h0006), rc(16'h0007), rc(16'h0008),
              rc(16'h0009),
              rc(16'h000A), rc(16'h000B), rc(16'h000C), rc(16'h000D),
              rc(16'hFFFF), rc(16'h000E)});
    endtask

    // direct word loads and stores, high byte at the lower address
    task automatic test_dir_words;
        run('{8'hDC, 8'h50, 8'hDD, 8'h60, 8'h18, 8'hDE, 8'h70, 8'h18,
              8'hDF, 8'h80},
            '{rc(16'h0000), rc(16'h0001), rc(16'h0050),
              rc(16'h0051),
              rc(16'h0002), rc(16'h0003), wc(16'h0060, REG[15:8]),
              wc(16'h0061, REG[7:0]),
              rc(16'h0004), rc(16'h0005), rc(16'h0006), rc(16'h0070),
              rc(16'h0071),
              rc(16'h0007), rc(16'h0008), rc(16'h0009),
              wc(16'h0080, REG[15:8]),
              wc(16'h0081, REG[7:0]),
              rc(16'h000A)});
    endtask

    // verdict and end of run
    task test_done;
        if (fails == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // watchdog: the three programs need well under 200 cycles
    initial
    begin
        repeat (2000) @(posedge sys_clk);
        fails++;
        test_done();
    end

    initial
    begin
        test_byte_ops();
        test_imm_words();
        test_dir_words();
        test_done();
    end
endmodule
